/* design/msf_pkg.sv */
// Package: register map, field layouts, rates and timing for the filter config block
package msf_pkg;
  // Register offsets
  localparam logic [7:0] MSF_GYRO_RANGE_FILTER_CFG_ADDR = 8'h1b;
  localparam logic [7:0] MSF_ACCEL_RANGE_CFG_ADDR = 8'h1c;
  localparam logic [7:0] MSF_ACCEL_FILTER_CFG_ADDR = 8'h1d;
  localparam logic [7:0] MSF_LOW_POWER_MODE_CFG_ADDR = 8'h1e;
  // Writable-bit masks, reserved bits held at zero
  localparam logic [7:0] MSF_GYRO_CFG_MASK = 8'hfb;
  localparam logic [7:0] MSF_ACCEL_CFG_MASK = 8'hf8;
  localparam logic [7:0] MSF_ACCEL2_CFG_MASK = 8'h3f;
  localparam logic [7:0] MSF_LP_CFG_MASK = 8'hf0;
  // Reset values
  localparam logic [7:0] MSF_CFG_RESET = 8'h00;
  // Field positions
  localparam int MSF_SELFTEST_LSB = 5;
  localparam int MSF_RANGE_LSB = 3;
  localparam int MSF_ACCEL_AVG_LSB = 4;
  localparam int MSF_ACCEL_BYPASS_BIT = 3;
  localparam int MSF_GYRO_CYCLE_BIT = 7;
  localparam int MSF_GYRO_AVG_LSB = 4;
  // Lowpass settings that keep the 8 kHz gyro rate
  localparam logic [2:0] MSF_GYRO_LP_WIDE_LO = 3'h0;
  localparam logic [2:0] MSF_GYRO_LP_WIDE_HI = 3'h7;
  // Path rates in kHz
  localparam logic [5:0] MSF_RATE_BYPASS_KHZ = 6'h20;
  localparam logic [5:0] MSF_RATE_WIDE_KHZ = 6'h08;
  localparam logic [5:0] MSF_RATE_NARROW_KHZ = 6'h01;
  localparam logic [5:0] MSF_ACCEL_RATE_BYPASS_KHZ = 6'h04;
  // Log2 of accel averaging depth at setting 0 (4 samples)
  localparam logic [2:0] MSF_ACCEL_AVG_LOG2_BASE = 3'h2;
  // Gyro filter modes
  typedef enum logic [1:0] {
    MSF_GF_LOWPASS = 2'b00,
    MSF_GF_BYPASS = 2'b01,
    MSF_GF_AVERAGE = 2'b11
  } msf_gyro_filter_type;
  // Clock and internal sample rate
  localparam int MSF_CLOCK_HZ = 200_000_000;
  localparam int MSF_INTERNAL_RATE_HZ = 1000;
  localparam int MSF_TICK_CYCLES = MSF_CLOCK_HZ / MSF_INTERNAL_RATE_HZ;
  localparam int MSF_CYCLES_PER_US = MSF_CLOCK_HZ / 1_000_000;
  // Accel duty-cycle on-times in microseconds: bypassed, then 4x..32x
  localparam int MSF_TON_BYPASS_US = 1084;
  localparam int MSF_TON_AVG4_US = 1840;
  localparam int MSF_TON_AVG8_US = 2840;
  localparam int MSF_TON_AVG16_US = 4840;
  localparam int MSF_TON_AVG32_US = 8840;
endpackage : msf_pkg

/* design/msf_filter_cfg.sv */
// Filter, range, self-test and low-power configuration registers with rate timing
`timescale 1ns/1ps
// Function
// - Gyro range from bits 4:3
// - Accel range from bits 4:3
// - Gyro bypass field bits 1:0 selects filter
// - Accel bypass bit 3 gives 4 kHz path
// - Accel lowpass setting bits 2:0 when not bypassed
// - Accel low-power averaging 4 to 32 samples
// - Output rate reduced by one plus divider
// - Accel duty-cycled, on-time grows with depth
// - Gyro cycle bit 7 enables low-power, resets 0
// - Gyro averaging bits 6:4, 1x to 128x, reset 0
// - Gyro low-power ignores lowpass setting
// - Internal sample rate is 1 kHz
// - Gyro rate 32, 8 or 1 kHz by setting
module msf_filter_cfg
  import msf_pkg::*;
#(
  parameter int TICK_CYCLES = MSF_TICK_CYCLES,
  parameter int CYCLES_PER_US = MSF_CYCLES_PER_US
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Register access from the serial interface
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Settings held in neighbouring registers
  input wire logic [7:0] i_sample_rate_divider,
  input wire logic [2:0] i_gyro_lowpass_setting,
  input wire logic i_accel_low_power,
  // Gyro configuration outputs
  output logic [2:0] o_gyro_selftest,
  output logic [1:0] o_gyro_range_select,
  output logic [1:0] o_gyro_filter_mode,
  output logic [5:0] o_gyro_rate_khz,
  output logic o_gyro_cycle_en,
  output logic [2:0] o_gyro_avg_log2,
  // Accel configuration outputs
  output logic [2:0] o_accel_selftest,
  output logic [1:0] o_accel_range_select,
  output logic o_accel_lowpass_active,
  output logic [2:0] o_accel_lowpass_setting,
  output logic [5:0] o_accel_rate_khz,
  output logic [2:0] o_accel_avg_log2,
  output logic o_accel_power_on,
  // Sample timing
  output logic o_sample_strobe
);

  // All state in one record: config, read data, timing and derived modes
  typedef struct packed {
    logic [7:0] gyro_cfg;
    logic [7:0] accel_cfg;
    logic [7:0] accel2_cfg;
    logic [7:0] lp_cfg;
    logic [7:0] rdata;
    logic [31:0] tick_cnt;
    logic [7:0] div_cnt;
    logic strobe;
    logic [31:0] on_cnt;
    logic power_on;
    logic [1:0] gyro_mode;
    logic [5:0] gyro_rate;
    logic accel_lp_active;
    logic [5:0] accel_rate;
    logic [2:0] accel_avg;
  } msf_state_type;

  msf_state_type st_r;
  msf_state_type st_nxt;

  // On-time counts from the edge after a strobe
  // Deeper averaging needs more samples, so the accel stays powered longer
  // Accel on-time in cycles for the current bypass and depth
  function automatic logic [31:0] msf_ton_cycles(input logic bypass, input logic [1:0] depth);
    int us;
    us = MSF_TON_BYPASS_US;
    if (!bypass) begin
      case (depth)
        2'h0: us = MSF_TON_AVG4_US;
        2'h1: us = MSF_TON_AVG8_US;
        2'h2: us = MSF_TON_AVG16_US;
        default: us = MSF_TON_AVG32_US;
      endcase
    end
    return 32'(us * CYCLES_PER_US);
  endfunction : msf_ton_cycles

  // Register access, decode and timing
  always_comb begin
    logic a_bypass;
    logic [1:0] a_depth;
    logic [1:0] g_bypass;
    logic [2:0] a_lp;
    a_bypass = 1'b0;
    a_depth = 2'h0;
    g_bypass = 2'h0;
    a_lp = 3'h0;
    st_nxt = st_r;
    // Writes keep reserved bits at zero
    if (i_reg_wr) begin
      case (i_reg_addr)
        MSF_GYRO_RANGE_FILTER_CFG_ADDR: st_nxt.gyro_cfg = i_reg_wdata & MSF_GYRO_CFG_MASK;
        MSF_ACCEL_RANGE_CFG_ADDR: st_nxt.accel_cfg = i_reg_wdata & MSF_ACCEL_CFG_MASK;
        MSF_ACCEL_FILTER_CFG_ADDR: st_nxt.accel2_cfg = i_reg_wdata & MSF_ACCEL2_CFG_MASK;
        MSF_LOW_POWER_MODE_CFG_ADDR: st_nxt.lp_cfg = i_reg_wdata & MSF_LP_CFG_MASK;
        default: ;
      endcase
    end
    // Read data, unmapped addresses read zero
    // A read in the same cycle as a write returns the old value
    if (i_reg_rd) begin
      case (i_reg_addr)
        MSF_GYRO_RANGE_FILTER_CFG_ADDR: st_nxt.rdata = st_r.gyro_cfg;
        MSF_ACCEL_RANGE_CFG_ADDR: st_nxt.rdata = st_r.accel_cfg;
        MSF_ACCEL_FILTER_CFG_ADDR: st_nxt.rdata = st_r.accel2_cfg;
        MSF_LOW_POWER_MODE_CFG_ADDR: st_nxt.rdata = st_r.lp_cfg;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // Gyro filter mode and path rate
    // Cycle mode wins over the bypass field and ignores the lowpass setting
    // Derived values lag the register field by one edge
    g_bypass = st_r.gyro_cfg[1:0];
    if (st_r.lp_cfg[MSF_GYRO_CYCLE_BIT]) begin
      st_nxt.gyro_mode = MSF_GF_AVERAGE;
      st_nxt.gyro_rate = MSF_RATE_NARROW_KHZ;
    end else if (g_bypass != 2'h0) begin
      st_nxt.gyro_mode = MSF_GF_BYPASS;
      st_nxt.gyro_rate = MSF_RATE_BYPASS_KHZ;
    end else begin
      st_nxt.gyro_mode = MSF_GF_LOWPASS;
      if (i_gyro_lowpass_setting == MSF_GYRO_LP_WIDE_LO ||
          i_gyro_lowpass_setting == MSF_GYRO_LP_WIDE_HI) begin
        st_nxt.gyro_rate = MSF_RATE_WIDE_KHZ;
      end else begin
        st_nxt.gyro_rate = MSF_RATE_NARROW_KHZ;
      end
    end
    // Accel filter path and averaging depth
    // Bypass gives the 4 kHz path; averaging only counts in low-power mode
    a_bypass = st_r.accel2_cfg[MSF_ACCEL_BYPASS_BIT];
    a_depth = st_r.accel2_cfg[MSF_ACCEL_AVG_LSB +: 2];
    a_lp = st_r.accel2_cfg[2:0];
    st_nxt.accel_lp_active = ~a_bypass;
    st_nxt.accel_rate = a_bypass ? MSF_ACCEL_RATE_BYPASS_KHZ : MSF_RATE_NARROW_KHZ;
    st_nxt.accel_avg = (i_accel_low_power && !a_bypass) ?
        MSF_ACCEL_AVG_LOG2_BASE + {1'b0, a_depth} : 3'h0;
    // 1 kHz internal tick
    // Compare by >= so a lowered divider restarts at once, not after a wrap
    st_nxt.strobe = 1'b0;
    if (st_r.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      st_nxt.tick_cnt = 32'h0;
      // Divide the tick by one plus the divider
      if (st_r.div_cnt >= i_sample_rate_divider) begin
        st_nxt.div_cnt = 8'h00;
        st_nxt.strobe = 1'b1;
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 8'h01;
      end
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 32'h1;
    end
    // Accel duty cycle: power for on-time from each output sample
    // A strobe period shorter than the on-time keeps the accel powered
    // Leaving low-power mode powers the accel on the next edge
    if (!i_accel_low_power) begin
      st_nxt.power_on = 1'b1;
      st_nxt.on_cnt = 32'h0;
    end else if (st_r.strobe) begin
      st_nxt.power_on = 1'b1;
      st_nxt.on_cnt = msf_ton_cycles(a_bypass, a_depth) - 32'h1;
    end else if (st_r.on_cnt != 32'h0) begin
      st_nxt.on_cnt = st_r.on_cnt - 32'h1;
    end else begin
      st_nxt.power_on = 1'b0;
    end
    // Lowpass setting 0 still uses the filter unless bypassed
    if (a_lp == 3'h0) begin
      st_nxt.accel_lp_active = ~a_bypass;
    end
  end

  // State register
  // Accel starts powered, as in normal mode; config fields clear to zero
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_r <= '0;
      st_r.gyro_cfg <= MSF_CFG_RESET;
      st_r.lp_cfg <= MSF_CFG_RESET;
      st_r.power_on <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops
  // Self-test, range and low-power fields come straight off the registers
  assign o_reg_rdata = st_r.rdata;
  assign o_gyro_selftest = st_r.gyro_cfg[MSF_SELFTEST_LSB +: 3];
  assign o_gyro_range_select = st_r.gyro_cfg[MSF_RANGE_LSB +: 2];
  assign o_gyro_filter_mode = st_r.gyro_mode;
  assign o_gyro_rate_khz = st_r.gyro_rate;
  assign o_gyro_cycle_en = st_r.lp_cfg[MSF_GYRO_CYCLE_BIT];
  assign o_gyro_avg_log2 = st_r.lp_cfg[MSF_GYRO_AVG_LSB +: 3];
  assign o_accel_selftest = st_r.accel_cfg[MSF_SELFTEST_LSB +: 3];
  assign o_accel_range_select = st_r.accel_cfg[MSF_RANGE_LSB +: 2];
  assign o_accel_lowpass_active = st_r.accel_lp_active;
  assign o_accel_lowpass_setting = st_r.accel2_cfg[2:0];
  assign o_accel_rate_khz = st_r.accel_rate;
  assign o_accel_avg_log2 = st_r.accel_avg;
  assign o_accel_power_on = st_r.power_on;
  assign o_sample_strobe = st_r.strobe;

endmodule : msf_filter_cfg

/* verif/msf_filter_cfg_props.sv */
// Checker for the filter configuration block
`timescale 1ns/1ps
module msf_filter_cfg_props (
  input wire logic i_clock, i_rst, i_reg_wr, i_reg_rd, i_accel_low_power,
  input wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
  input wire logic [1:0] o_gyro_range_select, o_gyro_filter_mode, o_accel_range_select,
  input wire logic [5:0] o_gyro_rate_khz, o_accel_rate_khz,
  input wire logic [2:0] o_gyro_avg_log2,
  input wire logic o_gyro_cycle_en, o_accel_power_on, o_sample_strobe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Writes land in fields one edge later, derived outputs two
  a_gyro_range: assert property (i_reg_wr && i_reg_addr == 8'h1b
    |=> o_gyro_range_select == $past(i_reg_wdata[4:3])) else $error("gyro range");
  a_accel_range: assert property (i_reg_wr && i_reg_addr == 8'h1c
    |=> o_accel_range_select == $past(i_reg_wdata[4:3])) else $error("accel range");
  a_lp_fields: assert property (i_reg_wr && i_reg_addr == 8'h1e
    |=> {o_gyro_cycle_en, o_gyro_avg_log2} == $past(i_reg_wdata[7:4])) else $error("lp");
  a_accel_bypass: assert property (i_reg_wr && i_reg_addr == 8'h1d && i_reg_wdata[3]
    ##1 !(i_reg_wr && i_reg_addr == 8'h1d) |=> o_accel_rate_khz == 6'h04)
    else $error("accel bypass rate");
  a_bypass_rate: assert property (o_gyro_filter_mode == 2'b01
    |-> o_gyro_rate_khz == 6'h20) else $error("gyro bypass rate");
  a_cycle_ignore: assert property (o_gyro_cycle_en && $past(o_gyro_cycle_en)
    |-> o_gyro_filter_mode == 2'b11 && o_gyro_rate_khz == 6'h01) else $error("cycle mode");
  a_reserved_rd: assert property (i_reg_rd && i_reg_addr == 8'h1e
    |=> o_reg_rdata[3:0] == 4'h0) else $error("reserved bits");
  a_strobe_pulse: assert property (o_sample_strobe |=> !o_sample_strobe)
    else $error("strobe width");
  a_power_full: assert property (!i_accel_low_power |=> o_accel_power_on)
    else $error("accel power");
endmodule : msf_filter_cfg_props
bind msf_filter_cfg msf_filter_cfg_props i_msf_filter_cfg_props (
  .i_clock(i_clock), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_accel_low_power(i_accel_low_power), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_gyro_range_select(o_gyro_range_select), .o_gyro_filter_mode(o_gyro_filter_mode),
  .o_accel_range_select(o_accel_range_select), .o_gyro_rate_khz(o_gyro_rate_khz),
  .o_accel_rate_khz(o_accel_rate_khz), .o_gyro_avg_log2(o_gyro_avg_log2),
  .o_gyro_cycle_en(o_gyro_cycle_en), .o_accel_power_on(o_accel_power_on),
  .o_sample_strobe(o_sample_strobe)
);

/* verif/msf_host.sv */
// Host model driving the register strobe port
`timescale 1ns/1ps
module msf_host (
  input wire logic i_clock,
  input wire logic [7:0] i_reg_rdata,
  output logic o_reg_wr = 1'b0,
  output logic o_reg_rd = 1'b0,
  output logic [7:0] o_reg_addr = 8'h00,
  output logic [7:0] o_reg_wdata = 8'h00
);
  // One-cycle strobe; released lines show the inverse, never a stale value
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge i_clock);
    #1;
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = w;
    o_reg_rd = !w;
    @(posedge i_clock);
    #1;
    q = i_reg_rdata;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask : xfer
endmodule : msf_host

/* verif/tb.sv */
// Self-checking bench: random register traffic and strobe timing
`timescale 1ns/1ps
module tb;
  import msf_pkg::*;
  localparam int TICK = 8;
  localparam int US = 1;
  localparam logic [7:0] msk [4] = '{8'hfb, 8'hf8, 8'h3f, 8'hf0};
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_accel_low_power = 1'b0;
  logic [2:0] i_gyro_lowpass_setting = 3'h0;
  logic [7:0] i_sample_rate_divider = 8'h00;
  logic i_reg_wr, i_reg_rd, o_gyro_cycle_en, o_accel_lowpass_active, o_accel_power_on;
  logic o_sample_strobe;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, q, d, a;
  logic [7:0] sh [4] = '{default: 8'h00};
  logic [2:0] o_gyro_selftest, o_gyro_avg_log2, o_accel_selftest, o_accel_lowpass_setting;
  logic [2:0] o_accel_avg_log2;
  logic [1:0] o_gyro_range_select, o_gyro_filter_mode, o_accel_range_select;
  logic [5:0] o_gyro_rate_khz, o_accel_rate_khz;
  int failures = 0;
  int comparisons = 0;
  int seed = 32'h2c8f;
  // 200 MHz clock
  always #2.5 i_clock = ~i_clock;
  msf_host i_msf_host (.i_clock(i_clock), .i_reg_rdata(o_reg_rdata), .o_reg_wr(i_reg_wr),
    .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));
  // Short tick and one cycle per us; the longest strobe period outlasts short on-times
  msf_filter_cfg #(.TICK_CYCLES(TICK), .CYCLES_PER_US(US)) i_msf_filter_cfg (
    .i_clock(i_clock), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_sample_rate_divider(i_sample_rate_divider),
    .i_gyro_lowpass_setting(i_gyro_lowpass_setting), .i_accel_low_power(i_accel_low_power),
    .o_gyro_selftest(o_gyro_selftest), .o_gyro_range_select(o_gyro_range_select),
    .o_gyro_filter_mode(o_gyro_filter_mode), .o_gyro_rate_khz(o_gyro_rate_khz),
    .o_gyro_cycle_en(o_gyro_cycle_en), .o_gyro_avg_log2(o_gyro_avg_log2),
    .o_accel_selftest(o_accel_selftest), .o_accel_range_select(o_accel_range_select),
    .o_accel_lowpass_active(o_accel_lowpass_active),
    .o_accel_lowpass_setting(o_accel_lowpass_setting), .o_accel_rate_khz(o_accel_rate_khz),
    .o_accel_avg_log2(o_accel_avg_log2), .o_accel_power_on(o_accel_power_on),
    .o_sample_strobe(o_sample_strobe)
  );
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Cycle counts, compared as 16-bit values
  task automatic chk_count(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_count
  task automatic test_done();
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // Gyro filter mode and path rate implied by the settings
  function automatic logic [7:0] exp_gyro(input logic [7:0] g, l, input logic [2:0] s);
    if (l[7]) return {2'b11, 6'h01};
    if (g[1:0] != 2'b00) return {2'b01, 6'h20};
    return {2'b00, (s == 3'h0 || s == 3'h7) ? 6'h08 : 6'h01};
  endfunction : exp_gyro
  // Accel lowpass flag, setting and averaging depth
  function automatic logic [7:0] exp_accel(input logic [7:0] c, input logic lp);
    return {1'b0, !c[3], c[2:0], (lp && !c[3]) ? 3'h2 + {1'b0, c[5:4]} : 3'h0};
  endfunction : exp_accel
  // Count edges up to the next strobe; a used-up bound ends the run
  task automatic wait_strobe(output int c);
    c = 0;
    do begin
      @(posedge i_clock);
      #1;
      c++;
    end while (o_sample_strobe !== 1'b1 && c < 3000);
    if (c >= 3000) begin
      failures++;
      test_done();
    end
  endtask : wait_strobe
  // Settle on a new divider, then time one full strobe period
  task automatic period(input logic [7:0] dv);
    int c;
    i_sample_rate_divider = dv;
    repeat (3) wait_strobe(c);
    chk_count("strobe_period", 16'(TICK * (1 + dv)), 16'(c));
  endtask : period
  // Low-power accel: off at a strobe, then powered for the on-time
  task automatic duty(input logic [7:0] cfg, input int ton);
    int c;
    i_accel_low_power = 1'b1;
    i_sample_rate_divider = 8'hff;
    i_msf_host.xfer(1'b1, 8'h1d, cfg, q);
    repeat (2) wait_strobe(c);
    chk("accel_power_idle", 8'h00, {7'h0, o_accel_power_on});
    c = 0;
    @(posedge i_clock);
    #1;
    while (o_accel_power_on === 1'b1 && c < 4000) begin
      c++;
      @(posedge i_clock);
      #1;
    end
    if (c >= 4000) begin
      failures++;
      test_done();
    end
    chk_count("accel_on_time", 16'(ton), 16'(c));
  endtask : duty
  // Hold reset for n edges, then every register must read back zero
  task automatic reset_check(input int n);
    i_rst = 1'b1;
    repeat (n) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      i_msf_host.xfer(1'b0, 8'h1b + 8'(i), 8'h00, q);
      chk("reset_value", 8'h00, q);
    end
  endtask : reset_check
  initial begin
    reset_check(10);
    // All-ones corner first, then random traffic with one unmapped address
    for (int n = 0; n < 80; n++) begin
      a = (n < 4) ? 8'h1b + 8'(n) : 8'h1b + 8'({$random(seed)} % 5);
      d = (n < 4) ? 8'hff : 8'($random(seed));
      i_gyro_lowpass_setting = 3'($random(seed));
      i_accel_low_power = 1'($random(seed));
      i_msf_host.xfer(1'b1, a, d, q);
      if (a != 8'h1f) sh[a - 8'h1b] = d & msk[a - 8'h1b];
      i_msf_host.xfer(1'b0, a, 8'h00, q);
      chk("readback", (a == 8'h1f) ? 8'h00 : sh[a - 8'h1b], q);
      chk("gyro_fields", {3'h0, sh[0][7:3]}, {3'h0, o_gyro_selftest, o_gyro_range_select});
      chk("gyro_mode_rate", exp_gyro(sh[0], sh[3], i_gyro_lowpass_setting),
        {o_gyro_filter_mode, o_gyro_rate_khz});
      chk("gyro_low_power", sh[3], {o_gyro_cycle_en, o_gyro_avg_log2, 4'h0});
      chk("accel_fields", {3'h0, sh[1][7:3]}, {3'h0, o_accel_selftest, o_accel_range_select});
      chk("accel_filter", exp_accel(sh[2], i_accel_low_power), {1'b0, o_accel_lowpass_active,
        o_accel_lowpass_setting, o_accel_avg_log2});
      chk("accel_rate", sh[2][3] ? 8'h04 : 8'h01, {2'h0, o_accel_rate_khz});
    end
    reset_check(2);
    period(8'h00);
    period(8'h01);
    period(8'h3e);
    period(8'({$random(seed)} % 63));
    duty(8'h08, MSF_TON_BYPASS_US * US);
    duty(8'h00, MSF_TON_AVG4_US * US);
    test_done();
  end
endmodule : tb
